// ---- dv/icl_ctrl_assertions.sv ----
`timescale 1ns/10ps
module icl_ctrl_assertions (
  input wire logic i_ref_clk, // Clock
  input wire logic i_resetn, // Reset, low
  input wire logic i_creg_wr, // Write strobe
  input wire logic i_creg_super, // Supervisor
  input wire logic [11:0] i_creg_code, // Code
  input wire logic [31:0] i_creg_wdata, // Write data
  input wire logic [31:0] o_creg_rdata, // Read data
  input wire logic i_sweep_dbg, // Debug sweep
  input wire logic i_fetch, // Fetch
  input wire logic [31:0] i_fetch_addr, // Fetch address
  input wire logic o_fetch_ready, // Ready
  input wire logic o_fetch_hit, // Hit
  input wire logic o_ext_req, // Ext request
  input wire logic [31:0] o_ext_addr, // Ext address
  input wire logic o_ext_line, // Line burst
  input wire logic o_ext_word // Word fetch
);
  import icl_pkg::*;
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_resetn);
  // ==========
  // Sequences
  sequence s_take;
    i_fetch && o_fetch_ready;
  endsequence
  sequence s_miss;
    s_take ##0 !o_fetch_hit;
  endsequence
  sequence s_swp;
    i_sweep_dbg || (i_creg_wr && i_creg_super &&
      i_creg_code == ICL_CODE_CTRL && i_creg_wdata[ICL_CC_INV_ALL]);
  endsequence
  // ==========
  // Properties
  property p_sweep_hold;
    s_swp |=> !o_fetch_ready [*8];
  endproperty
  a_sweep_hold: assert property (p_sweep_hold)
    else $error("fetch not held in sweep");
  property p_miss_req;
    s_miss |=> o_ext_req && o_ext_addr[31:2] == $past(i_fetch_addr[31:2]);
  endproperty
  a_miss_req: assert property (p_miss_req)
    else $error("miss without ext request");
  property p_req_busy;
    o_ext_req |-> !o_fetch_ready;
  endproperty
  a_req_busy: assert property (p_req_busy)
    else $error("ready during ext fetch");
  property p_req_pulse;
    o_ext_req |=> !o_ext_req;
  endproperty
  a_req_pulse: assert property (p_req_pulse)
    else $error("ext request too long");
  property p_hit_take;
    o_fetch_hit |-> s_take;
  endproperty
  a_hit_take: assert property (p_hit_take)
    else $error("hit without fetch");
  property p_rdata;
    o_creg_rdata == 32'h0000_0000;
  endproperty
  a_rdata: assert property (p_rdata)
    else $error("register read not zero");
  property p_bypass;
    o_ext_req && o_ext_word |-> !o_ext_line;
  endproperty
  a_bypass: assert property (p_bypass)
    else $error("word fetch as line");
  // Idle port only, so an outstanding miss cannot mask it
  property p_nosuper;
    i_creg_wr && !i_creg_super && o_fetch_ready && !i_fetch &&
      !i_sweep_dbg |=> o_fetch_ready;
  endproperty
  a_nosuper: assert property (p_nosuper)
    else $error("user write took effect");
endmodule : icl_ctrl_assertions

bind icl_ctrl icl_ctrl_assertions chk_u (.*);

// ---- dv/icl_ext_model.sv ----
`timescale 1ns/10ps
module icl_ext_model (
  input wire logic i_ref_clk, // Clock
  input wire logic i_req, // Fetch request
  input wire logic [31:0] i_addr, // Critical longword
  input wire logic i_line, // Line burst
  output logic o_ack, // Beat valid
  output logic [31:0] o_data // Beat data
);
  // ==========
  // Beats, slower on odd beats
  initial begin
    o_ack = 0;
    o_data = 0;
    forever begin
      @(posedge i_ref_clk);
      if (i_req) begin
        for (int k = 0; k < (i_line ? 4 : 1); k++) begin
          repeat (k % 2) begin
            #1 o_data = ~o_data;
            @(posedge i_ref_clk);
          end
          #1 o_ack = 1;
          o_data = {i_addr[31:4], i_addr[3:2] + 2'(k), 2'b00};
          o_data = o_data ^ 32'h5A5A_0000;
          @(posedge i_ref_clk);
          #1 o_ack = 0;
          o_data = ~o_data;
        end
      end
    end
  end
endmodule : icl_ext_model

// ---- dv/test_icl_ctrl.sv ----
`timescale 1ns/10ps
module test_icl_ctrl;
  import icl_pkg::*;
  logic i_ref_clk = 0, i_resetn = 0, i_creg_wr = 0, i_creg_rd = 0;
  logic i_creg_super = 0, i_line_inv = 0, i_line_inv_dbg = 0;
  logic i_sweep_dbg = 0, i_fetch = 0, i_fetch_super = 1;
  logic [11:0] i_creg_code = 0;
  logic [31:0] i_creg_wdata = 0, i_line_inv_addr = 0, i_fetch_addr = 0;
  logic [31:0] o_creg_rdata, o_fetch_data, o_ext_addr, i_ext_data;
  logic o_fetch_ready, o_fetch_hit, o_ext_req, o_ext_line, o_ext_word;
  logic i_ext_ack, pend = 0, ln;
  icl_attr_t o_attr;
  logic [31:0] q[$];
  logic [31:0] a;
  int err_total = 0, checked = 0, seed = 35;
  icl_ctrl dut_u (.*);
  icl_ext_model ext_u (.i_ref_clk(i_ref_clk), .i_req(o_ext_req),
    .i_addr(o_ext_addr), .i_line(o_ext_line), .o_ack(i_ext_ack),
    .o_data(i_ext_data));
  always #25 i_ref_clk = ~i_ref_clk;
  // ==========
  // Tasks
  task automatic check(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      err_total++;
      $display("CHECK FAILED t=%0t seen %h exp %h", $time, s, e);
    end
  endtask : check
  task automatic creg(input logic [11:0] c, input logic [31:0] d,
    input logic s, input logic r);
    @(posedge i_ref_clk);
    #1 {i_creg_wr, i_creg_rd, i_creg_super} = {~r, r, s};
    {i_creg_code, i_creg_wdata} = {c, d};
    @(posedge i_ref_clk);
    #1 {i_creg_wr, i_creg_rd} = 2'b00;
  endtask : creg
  task automatic fetch(input logic [31:0] a, input logic h,
    input logic ln);
    int n = 0;
    @(posedge i_ref_clk);
    #1 i_fetch = 1;
    i_fetch_addr = a;
    // Settled values mid-cycle decide the coming acceptance edge
    @(negedge i_ref_clk);
    while (!o_fetch_ready && n++ < 99) @(negedge i_ref_clk);
    check(o_fetch_hit, h);
    for (int k = 0; k < (!h && ln ? 4 : 1); k++)
      q.push_back({a[31:4], a[3:2] + 2'(k), 2'b00} ^ 32'h5A5A_0000);
    @(posedge i_ref_clk);
    #1 i_fetch = 0;
    if (!h) begin
      @(negedge i_ref_clk);
      check(o_ext_line, ln);
    end
    while (!o_fetch_ready && n++ < 99) @(negedge i_ref_clk);
  endtask : fetch
  task automatic swp_len();
    int n = 0;
    // One look per cycle, mid-cycle
    @(negedge i_ref_clk);
    while (!o_fetch_ready && n < 99) begin
      n++;
      @(negedge i_ref_clk);
    end
    check(n, 32);
  endtask : swp_len
  task automatic linv(input logic d, input logic [31:0] a);
    @(posedge i_ref_clk);
    #1 {i_line_inv, i_line_inv_dbg, i_line_inv_addr} = {~d, d, a};
    @(posedge i_ref_clk);
    #1 {i_line_inv, i_line_inv_dbg} = 2'b00;
  endtask : linv
  task automatic finish_test();
    $display("checks %0d errors %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : finish_test
  // ==========
  // Result monitor, one note per data beat
  always @(negedge i_ref_clk) begin
    if (pend)
      check(o_fetch_data, q.size() ? q.pop_front() : ~o_fetch_data);
    pend <= (o_fetch_hit & i_fetch & o_fetch_ready) | i_ext_ack;
  end
  initial begin
    #200_000;
    err_total++;
    finish_test();
  end
  initial begin
    repeat (4) @(posedge i_ref_clk);
    #1 i_resetn = 1;
    check(o_fetch_ready, 1);
    creg(ICL_CODE_CTRL, 32'h0100_0000, 1, 0);
    swp_len();
    creg(ICL_CODE_CTRL, 32'h0100_0000, 1, 0);
    repeat (10) @(posedge i_ref_clk);
    #1 i_sweep_dbg = 1;
    @(posedge i_ref_clk);
    #1 i_sweep_dbg = 0;
    swp_len();
    for (int f = 0; f < 4; f++) begin
      creg(ICL_CODE_CTRL, 32'h8000_0000 | f, 1, 0);
      for (int o = 0; o < 4; o++) begin
        ln = f[1] || (f == 0 && o != 3) || (f == 1 && o < 2);
        a = {16'($random(seed)), 16'h1000 + 16'(f * 64 + o * 20)};
        fetch(a, 0, ln);
        if (ln)
          fetch(a ^ 32'h0000_0004, 1, 0);
      end
    end
    fetch(32'h0000_2140, 0, 1);
    fetch(32'h0000_2150, 0, 1);
    fetch(32'h0000_2140, 1, 0);
    linv(0, 32'h0000_2140);
    fetch(32'h0000_2140, 0, 1);
    creg(ICL_CODE_CTRL, 32'h9000_0003, 1, 0);
    creg(ICL_CODE_CTRL, 32'h0000_0000, 0, 0);
    linv(1, 32'h0000_2150);
    fetch(32'h0000_2150, 1, 0);
    creg(ICL_CODE_CTRL, 32'h8000_0202, 1, 0);
    fetch(32'h0000_2190, 0, 0);
    fetch(32'h0000_2194, 0, 0);
    check(o_ext_word, 0);
    creg(ICL_CODE_CTRL, 32'h8000_0602, 1, 0);
    fetch(32'h0000_21A8, 0, 1);
    fetch(32'h0000_21AC, 1, 0);
    fetch(32'h0000_21B0, 0, 1);
    fetch(32'h0000_21A8, 0, 1);
    creg(ICL_CODE_CTRL, 32'h0000_0603, 1, 0);
    fetch(32'h0000_21B2, 0, 0);
    check(o_ext_word, 1);
    creg(ICL_CODE_RA0, 32'h4000_C044, 1, 0);
    creg(ICL_CODE_RA1, 32'h4100_C020, 1, 0);
    creg(ICL_CODE_RA0, 32'h0000_0000, 0, 0);
    creg(12'h003, 32'hFFFF_FFFF, 1, 0);
    creg(12'h003, 32'h0000_0000, 1, 1);
    check(o_creg_rdata, 0);
    creg(ICL_CODE_RA1, 32'h0000_0000, 1, 1);
    check(o_creg_rdata, 0);
    i_fetch_addr = 32'h4012_3450;
    #1 check(o_attr, 3'b101);
    i_fetch_addr = 32'h4100_0000;
    #1 check(o_attr, 3'b010);
    i_fetch_addr = 32'h0200_0000;
    #1 check(o_attr, 3'b100);
    finish_test();
  end
endmodule : test_icl_ctrl

// ---- hw/icl_attr_sel.sv ----
`timescale 1ns/10ps
module icl_attr_sel (
  input wire logic [31:0] i_addr,  // Reference address
  input wire logic i_super,        // Supervisor reference
  input wire logic [31:0] i_ra0,   // Region register 0
  input wire logic [31:0] i_ra1,   // Region register 1
  input wire logic [31:0] i_cc,    // Cache control defaults
  output icl_pkg::icl_attr_t o_attr // Effective attributes
);
  import icl_pkg::*;
  function automatic logic hit(input logic [31:0] r);
    logic [7:0] diff;
    logic mode_ok;
    diff = (i_addr[31:24] ^ r[31:ICL_RA_BASE_LO]) & ~r[23:ICL_RA_MASK_LO];
    mode_ok = r[ICL_RA_SM_HI] | (r[ICL_RA_SM_LO] == i_super);
    return r[ICL_RA_EN] & mode_ok & (diff == 8'h00);
  endfunction : hit
  always_comb begin
    // Region 0 wins when both match
    if (hit(i_ra0)) begin
      o_attr = '{i_ra0[ICL_RA_NC], i_ra0[ICL_RA_BUFW], i_ra0[ICL_RA_WP]};
    end else if (hit(i_ra1)) begin
      o_attr = '{i_ra1[ICL_RA_NC], i_ra1[ICL_RA_BUFW], i_ra1[ICL_RA_WP]};
    end else begin
      o_attr = '{i_cc[ICL_CC_DEF_NC], i_cc[ICL_CC_DEF_BUFW],
        i_cc[ICL_CC_DEF_WP]};
    end
  end
endmodule : icl_attr_sel

// ---- hw/icl_ctrl.sv ----
`timescale 1ns/10ps
// Operation
// - Regions checked per reference, else defaults
// - Attributes: cacheable, buffered write, protect
// - Bit 24 sweeps tags, 32 cycles
// - Fetches stall during whole sweep
// - Line invalidate by bits 8:4, bit28 gates
// - Core or debug may invalidate
// - Reset clears control, keeps tags
// - Enabled cacheable double miss fetches externally
// - Fill size from field and offset
// - Critical longword first, wrapping order
// - Recent flag set on miss, cleared
// - Copy buffer only complete and recent
// - Bit 10 bursts noncacheable into buffer
// - Disabled cache bypasses, word/longword fetches
// - Noncacheable without bit 10: single longword
// - Registers by codes 002/004/005, supervisor
// - Unassigned codes, reserved bits read zero
// - Write-only registers read zero
// - Hit: valid tag equals address 31:9
// - Fill buffer beats array
// - Buffer valid per longword
module icl_ctrl (
  input wire logic i_ref_clk,          // 20 MHz clock
  input wire logic i_resetn,           // Async reset, low
  // Control register move
  input wire logic i_creg_wr,          // Move-to-control strobe
  input wire logic i_creg_rd,          // Move-from-control strobe
  input wire logic i_creg_super,       // Supervisor mode
  input wire logic [11:0] i_creg_code, // Control register code
  input wire logic [31:0] i_creg_wdata, // Write data
  output logic [31:0] o_creg_rdata,    // Read data, always zero
  // Line invalidate from core or debug, sweep from debug
  input wire logic i_line_inv,         // Line invalidate strobe
  input wire logic i_line_inv_dbg,     // Same from debug module
  input wire logic [31:0] i_line_inv_addr, // Source address
  input wire logic i_sweep_dbg,        // Sweep request from debug
  // Fetch port
  input wire logic i_fetch,            // Fetch request
  input wire logic i_fetch_super,      // Supervisor fetch
  input wire logic [31:0] i_fetch_addr, // Fetch address
  output logic o_fetch_ready,          // Fetch accepted
  output logic o_fetch_hit,            // Served from cache or buffer
  output logic [31:0] o_fetch_data,    // Hit data or external beat data
  output icl_pkg::icl_attr_t o_attr,   // Effective attributes
  // External bus controller
  output logic o_ext_req,              // External fetch request
  output logic [31:0] o_ext_addr,      // Longword address
  output logic o_ext_line,             // Line burst when high
  output logic o_ext_word,             // Word-size bypass fetch
  input wire logic i_ext_ack,          // Data beat valid
  input wire logic [31:0] i_ext_data   // Data beat
);
  import icl_pkg::*;
  // ==========================================================
  // State
  typedef struct packed {
    logic [31:0] cc;
    logic [31:0] ra0;
    logic [31:0] ra1;
    logic sweep;
    logic [4:0] sweep_idx;
    logic [31:4] fb_addr;
    logic [3:0] fb_vld;
    logic fb_mru;
    logic fb_nc;
    logic fb_live;
    logic [31:0] rdata;
    logic ext_req;
    logic [31:0] ext_addr;
    logic ext_line;
    logic ext_word;
    logic ext_busy;
  } icl_ctrl_t;
  icl_ctrl_t q, d;
  // Tags and data kept out of reset so reset leaves them alone
  logic [ICL_TAG_W-1:0] tag_q [ICL_LINES];
  logic [31:0] data_q [ICL_LINES*4];
  logic [31:0] fb_data_q [4];
  // Valid bits likewise survive reset; software must sweep first
  logic [ICL_LINES-1:0] valid_q, valid_d;
  icl_fill_if fill ();
  icl_attr_t attr;
  logic [4:0] idx;
  logic arr_hit, fb_hit, enabled, do_line, do_copy, miss, start_fill;
  logic wr_ok, line_inv;
  logic [4:0] fb_idx;
  assign enabled = q.cc[ICL_CC_ENABLE];
  assign idx = i_fetch_addr[8:4];
  assign fb_idx = q.fb_addr[8:4];
  icl_attr_sel u_attr (
    .i_addr(i_fetch_addr),
    .i_super(i_fetch_super),
    .i_ra0(q.ra0),
    .i_ra1(q.ra1),
    .i_cc(q.cc),
    .o_attr(attr)
  );
  icl_fill_seq u_seq (
    .i_ref_clk(i_ref_clk),
    .i_resetn(i_resetn),
    .i_ack(i_ext_ack & q.ext_busy & fill.busy),
    .f(fill.seq)
  );
  // ==========================================================
  // Lookup
  always_comb begin
    arr_hit = enabled && valid_q[idx] && !attr.noncache &&
      tag_q[idx] == i_fetch_addr[31:9];
    fb_hit = enabled && q.fb_live && q.fb_addr == i_fetch_addr[31:4] &&
      q.fb_vld[i_fetch_addr[3:2]];
    do_line = enabled && (!attr.noncache || q.cc[ICL_CC_NC_BURST]);
    // Sweep and outstanding external fetch hold the port
    o_fetch_ready = !q.sweep && !q.ext_busy && !q.ext_req;
    miss = i_fetch && o_fetch_ready && !fb_hit && !arr_hit;
    start_fill = miss && do_line;
    o_fetch_hit = i_fetch && o_fetch_ready && (fb_hit || arr_hit);
    // Copy needs a full, recent, cacheable buffer; freeze guards valid lines
    do_copy = miss && q.fb_live && q.fb_vld == 4'hF && q.fb_mru &&
      !q.fb_nc && !(q.cc[ICL_CC_FREEZE] && valid_q[fb_idx]);
    wr_ok = i_creg_wr && i_creg_super;
    line_inv = (i_line_inv || i_line_inv_dbg) &&
      !q.cc[ICL_CC_NO_LINE_INV];
  end
  assign fill.miss_addr = i_fetch_addr;
  assign fill.fill_size = q.cc[ICL_CC_FILL_HI:ICL_CC_FILL_LO];
  assign fill.start = start_fill;
  // ==========================================================
  // Next state
  always_comb begin
    d = q;
    valid_d = valid_q;
    d.rdata = 32'h0000_0000;
    if (wr_ok) begin
      case (i_creg_code)
        ICL_CODE_CTRL: d.cc = i_creg_wdata & ICL_CC_MASK &
          ~(32'h0000_0001 << ICL_CC_INV_ALL);
        ICL_CODE_RA0: d.ra0 = i_creg_wdata & ICL_RA_MASK;
        ICL_CODE_RA1: d.ra1 = i_creg_wdata & ICL_RA_MASK;
        default: d.rdata = 32'h0000_0000;
      endcase
    end
    // Sweep one entry per cycle
    if (q.sweep) begin
      valid_d[q.sweep_idx] = 1'b0;
      d.sweep_idx = q.sweep_idx + 5'd1;
      if (q.sweep_idx == ICL_INV_LAST) begin
        d.sweep = 1'b0;
      end
    end
    if (line_inv) begin
      valid_d[i_line_inv_addr[8:4]] = 1'b0;
    end
    if ((wr_ok && i_creg_code == ICL_CODE_CTRL &&
        i_creg_wdata[ICL_CC_INV_ALL]) || i_sweep_dbg) begin
      d.sweep = 1'b1;
      d.sweep_idx = 5'd0;
    end
    if (do_copy) begin
      valid_d[fb_idx] = 1'b1;
    end
    // Access to the buffer's own array slot makes the array recent
    if (i_fetch && o_fetch_ready && arr_hit && idx == fb_idx &&
        !fb_hit) begin
      d.fb_mru = 1'b0;
    end
    if (fill.busy && i_ext_ack && q.ext_busy) begin
      d.fb_vld[fill.word] = 1'b1;
      if (fill.word == q.ext_addr[3:2] + 2'd3 || !fill.line) begin
        d.ext_busy = 1'b0;
      end
    end
    if (q.ext_req) begin
      d.ext_req = 1'b0;
      // Every external fetch holds the port until its last beat
      d.ext_busy = 1'b1;
    end else if (q.ext_busy && !fill.busy && i_ext_ack) begin
      d.ext_busy = 1'b0;
    end
    if (miss) begin
      d.ext_req = 1'b1;
      d.ext_addr = {i_fetch_addr[31:2], 2'b00};
      d.ext_line = 1'b0;
      d.ext_word = !enabled && i_fetch_addr[1];
      if (start_fill) begin
        d.fb_addr = i_fetch_addr[31:4];
        d.fb_vld = 4'h0;
        d.fb_mru = 1'b1;
        d.fb_nc = attr.noncache;
        d.fb_live = 1'b1;
        d.ext_line = !(fill.fill_size == 2'b00 &&
          i_fetch_addr[3:2] == 2'b11) &&
          !(fill.fill_size == 2'b01 && i_fetch_addr[3]);
      end else begin
        d.fb_live = q.fb_live;
      end
    end
    if (!enabled) begin
      d.fb_live = 1'b0;
    end
  end
  // ==========================================================
  // Registers
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
  always_ff @(posedge i_ref_clk) begin
    valid_q <= valid_d;
    if (do_copy) begin
      tag_q[fb_idx] <= q.fb_addr[31:9];
    end
    if (fill.busy && i_ext_ack && q.ext_busy) begin
      fb_data_q[fill.word] <= i_ext_data;
    end
  end
  for (genvar w = 0; w < 4; w++) begin : g_copy
    always_ff @(posedge i_ref_clk) begin
      if (do_copy) begin
        data_q[{fb_idx, 2'(w)}] <= fb_data_q[w];
      end
    end
  end
  // ==========================================================
  // Outputs
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_fetch_data <= 32'h0000_0000;
    end else if (o_fetch_hit && fb_hit) begin
      o_fetch_data <= fb_data_q[i_fetch_addr[3:2]];
    end else if (o_fetch_hit && arr_hit) begin
      o_fetch_data <= data_q[i_fetch_addr[8:2]];
    end else if (q.ext_busy && i_ext_ack) begin
      o_fetch_data <= i_ext_data;
    end
  end
  assign o_creg_rdata = q.rdata;
  assign o_attr = attr;
  assign o_ext_req = q.ext_req;
  assign o_ext_addr = q.ext_addr;
  assign o_ext_line = q.ext_line;
  assign o_ext_word = q.ext_word;
endmodule : icl_ctrl

// ---- hw/icl_fill_if.sv ----
`timescale 1ns/10ps
interface icl_fill_if;
  logic [31:0] miss_addr;
  logic [1:0] fill_size;
  logic start;
  logic line;
  logic [1:0] word;
  logic busy;
  modport ctl (output miss_addr, output fill_size, output start,
    input line, input word, input busy);
  modport seq (input miss_addr, input fill_size, input start,
    output line, output word, output busy);
endinterface : icl_fill_if

// ---- hw/icl_fill_seq.sv ----
`timescale 1ns/10ps
module icl_fill_seq (
  input wire logic i_ref_clk, // Clock
  input wire logic i_resetn,  // Async reset, low
  input wire logic i_ack,     // Bus controller data beat
  icl_fill_if.seq f           // Fill request
);
  import icl_pkg::*;
  typedef struct packed {
    logic busy;
    logic line;
    logic [1:0] word;
    logic [1:0] left;
  } icl_seq_t;
  icl_seq_t q, d;
  logic want_line;
  always_comb begin
    // Fetch size by fill field and miss offset
    case (f.fill_size)
      2'b00: want_line = f.miss_addr[3:2] != 2'b11;
      2'b01: want_line = ~f.miss_addr[3];
      default: want_line = 1'b1;
    endcase
    d = q;
    if (f.start) begin
      d.busy = 1'b1;
      d.line = want_line;
      d.word = f.miss_addr[3:2];
      d.left = want_line ? 2'd3 : 2'd0;
    end else if (q.busy && i_ack) begin
      if (q.left == 2'd0) begin
        d.busy = 1'b0;
      end else begin
        d.left = q.left - 2'd1;
        d.word = q.word + 2'd1;
      end
    end
  end
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
  assign f.busy = q.busy;
  assign f.line = q.line;
  assign f.word = q.word;
endmodule : icl_fill_seq

// ---- hw/icl_pkg.sv ----
package icl_pkg;
  // Control register codes
  localparam logic [11:0] ICL_CODE_CTRL = 12'h002;
  localparam logic [11:0] ICL_CODE_RA0 = 12'h004;
  localparam logic [11:0] ICL_CODE_RA1 = 12'h005;
  // Cache control fields
  localparam int ICL_CC_ENABLE = 31;
  localparam int ICL_CC_NO_LINE_INV = 28;
  localparam int ICL_CC_FREEZE = 27;
  localparam int ICL_CC_INV_ALL = 24;
  localparam int ICL_CC_NC_BURST = 10;
  localparam int ICL_CC_DEF_NC = 9;
  localparam int ICL_CC_DEF_BUFW = 8;
  localparam int ICL_CC_DEF_WP = 5;
  localparam int ICL_CC_FILL_HI = 1;
  localparam int ICL_CC_FILL_LO = 0;
  localparam logic [31:0] ICL_CC_MASK = 32'h9900_0723;
  localparam logic [31:0] ICL_CC_RESET = 32'h0000_0000;
  // Region attribute fields
  localparam int ICL_RA_BASE_LO = 24;
  localparam int ICL_RA_MASK_LO = 16;
  localparam int ICL_RA_EN = 15;
  localparam int ICL_RA_SM_HI = 14;
  localparam int ICL_RA_SM_LO = 13;
  localparam int ICL_RA_NC = 6;
  localparam int ICL_RA_BUFW = 5;
  localparam int ICL_RA_WP = 2;
  localparam logic [31:0] ICL_RA_MASK = 32'hFFFF_E064;
  localparam logic [31:0] ICL_RA_RESET = 32'h0000_0000;
  // Geometry
  localparam int ICL_LINES = 32;
  localparam int ICL_IDX_W = 5;
  localparam int ICL_TAG_W = 23;
  localparam logic [4:0] ICL_INV_LAST = 5'h1F;

  typedef struct packed {
    logic noncache;
    logic bufw;
    logic wprot;
  } icl_attr_t;
endpackage : icl_pkg
